// ==== core/dac_addr_map.vh ====
`ifndef DAC_ADDR_MAP_VH
`define DAC_ADDR_MAP_VH

// ==========================================================
// Channel organisation
// ==========================================================
`define NUM_GROUPS        4
`define REGS_PER_GROUP    10
`define NUM_CHANNELS      40
`define DATA_W            14
`define CHAN_W            6

// ==========================================================
// Class select encodings {class_select_high, class_select_low}
// ==========================================================
`define CLASS_DATA        2'h3
`define CLASS_OFFSET      2'h2
`define CLASS_GAIN        2'h1
`define CLASS_SPECIAL     2'h0

// ==========================================================
// APB register offsets (byte addresses)
// ==========================================================
`define OFF_WRITE         12'h000
`define OFF_CONTROL       12'h004
`define OFF_STATUS        12'h008
`define OFF_READ_SEL      12'h00C
`define OFF_READ_DATA     12'h010

// ==========================================================
// Field positions of the write-port word
// ==========================================================
`define WR_DATA_LSB       0
`define WR_DATA_MSB       13
`define WR_INDEX_LSB      16
`define WR_INDEX_MSB      19
`define WR_MASK_LSB       20
`define WR_MASK_MSB       23
`define WR_CLASS_LSB      24
`define WR_CLASS_MSB      25

// ==========================================================
// Reset values
// ==========================================================
`define RST_DATA          14'h0000
`define RST_OFFSET        14'h2000
`define RST_GAIN          14'h3FFF
`define RST_CONTROL       1'b1

`endif

// ==== core/dac_chan_mem.v ====
`include "dac_addr_map.vh"

// ==========================================================
// Register storage for one class across all channels
// ==========================================================
module dac_chan_mem
#(
    parameter [13:0] RESET_VAL = 14'h0000   // Value of every word after reset
)
(
    input  wire                  pclk,      // Bus clock
    input  wire                  presetn,   // Async reset, active low
    input  wire [39:0]           wr_en,     // One write enable per channel
    input  wire [13:0]           wr_data,   // Word written to all enabled
    input  wire [5:0]            rd_chan,   // Channel to read back
    output reg  [13:0]           rd_data    // Registered read data
);

    wire [559:0] flat_words;                // All channel words side by side
    genvar g;

    // ==========================================================
    // Storage, one flop word per channel
    // ==========================================================
    // Each channel owns its word, so every flop has one driving process
    generate
        for (g = 0; g < 40; g = g + 1)
        begin : chan
            reg [13:0] word_q;              // This channel's word
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    word_q <= RESET_VAL;
                else if (wr_en[g])
                    word_q <= wr_data;
            end
            assign flat_words[g*14 +: 14] = word_q;
        end
    endgenerate

    // ==========================================================
    // Registered readback
    // ==========================================================
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_data <= 14'h0000;
        else if (rd_chan < 6'd40)
            rd_data <= flat_words[rd_chan*14 +: 14];
        else
            rd_data <= 14'h0000;            // Out of range reads zero
    end

endmodule

// ==== core/dac_channel_address_decoder.v ====
// Functional notes
// RL1: Eight-bit address reaches every channel register
// RL2: Upper nibble zero writes all 40
// RL3: Upper nibble bits enable groups A-D
// RL4: Lower nibble picks register 0-9 per group
// RL5: Same decoding for every register class
// RL6: Outputs start cleared to ground reference
// RL7: Class codes 11 data, 10 offset, 01 gain, 00 special
// RL8: Address and data captured on write strobe
// RL9: Index 10-15 with group mask: no update
//
// The APB slave port and the placing of the registers were decided locally.
`include "dac_addr_map.vh"

module dac_channel_address_decoder
(
    input  wire        pclk,               // Bus clock, 25 MHz
    input  wire        presetn,            // Async reset, active low
    input  wire        psel,               // APB select
    input  wire        penable,            // APB access phase
    input  wire        pwrite,             // APB direction
    input  wire [11:0] paddr,              // APB byte address
    input  wire [31:0] pwdata,             // APB write data
    output reg  [31:0] prdata,             // APB read data
    output reg         pready,             // APB ready
    output reg         pslverr,            // APB error
    output reg         output_clear_state, // Outputs forced to ground ref
    output reg  [1:0]  class_select_q,     // Class of last accepted write
    output reg  [39:0] chan_write_q,       // Pulse: channels hit by the write
    output reg         special_write_q,    // Pulse: special function write
    output reg  [13:0] special_data_q      // Last special function word
);

    // ==========================================================
    // Address decode function
    // ==========================================================
    // Returns the 40-bit channel mask for group mask and index
    // Broadcast ignores the index; an index past nine reaches nothing,
    // so a stray code can never spill into the next group
    function [39:0] decode_channels;
        input [3:0] group_mask_field;
        input [3:0] channel_index_field;
        integer     grp;
        begin
            decode_channels = 40'h00_0000_0000;
            if (group_mask_field == 4'h0)
                decode_channels = 40'hFF_FFFF_FFFF;       // see RL2
            else if (channel_index_field < 4'hA)          // see RL9
            begin
                for (grp = 0; grp < 4; grp = grp + 1)
                    if (group_mask_field[grp])            // see RL3
                        decode_channels[grp*10 + channel_index_field] = 1'b1; // see RL4
            end
        end
    endfunction

    // ==========================================================
    // Bus decode
    // ==========================================================
    // Only the first access cycle counts; the answer cycle must not
    // repeat the write while the host still holds the request
    wire        access   = psel & penable;               // APB access phase
    wire        wr_acc   = access & pwrite & ~pready;    // First access cycle
    wire        hit_wr   = wr_acc && (paddr == `OFF_WRITE);
    wire [1:0]  wr_class = pwdata[`WR_CLASS_MSB:`WR_CLASS_LSB];
    wire [3:0]  wr_mask  = pwdata[`WR_MASK_MSB:`WR_MASK_LSB];
    wire [3:0]  wr_index = pwdata[`WR_INDEX_MSB:`WR_INDEX_LSB];
    wire [13:0] wr_word  = pwdata[`WR_DATA_MSB:`WR_DATA_LSB];
    wire [39:0] wr_chans = hit_wr ? decode_channels(wr_mask, wr_index) : 40'h00_0000_0000; // see RL1

    // Per-class write enables; the same mask serves all classes
    // Special class reaches no channel store; it raises a pulse and latches its word in special_data_q
    wire [39:0] en_data   = (wr_class == `CLASS_DATA)   ? wr_chans : 40'h00_0000_0000; // see RL7
    wire [39:0] en_offset = (wr_class == `CLASS_OFFSET) ? wr_chans : 40'h00_0000_0000; // see RL5
    wire [39:0] en_gain   = (wr_class == `CLASS_GAIN)   ? wr_chans : 40'h00_0000_0000; // see RL5

    // Readback path state
    reg  [5:0]  read_sel_q;                // Readback channel select
    reg  [1:0]  read_class_q;              // Readback class select
    reg         rd_pending_q;              // Read data one cycle late
    wire [13:0] rd_data;                   // Memory readback
    wire [13:0] rd_offset;
    wire [13:0] rd_gain;

    // ==========================================================
    // Storage for the three classes
    // ==========================================================
    // Three copies of one store; only the enable and reset word differ
    // All three read the same channel, so a class switch costs no cycle
    dac_chan_mem #(.RESET_VAL(`RST_DATA)) data_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (en_data),
        .wr_data (wr_word),
        .rd_chan (read_sel_q),
        .rd_data (rd_data)
    );

    dac_chan_mem #(.RESET_VAL(`RST_OFFSET)) offset_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (en_offset),
        .wr_data (wr_word),
        .rd_chan (read_sel_q),
        .rd_data (rd_offset)
    );

    dac_chan_mem #(.RESET_VAL(`RST_GAIN)) gain_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (en_gain),
        .wr_data (wr_word),
        .rd_chan (read_sel_q),
        .rd_data (rd_gain)
    );

    // Readback mux, class chosen by software
    // Special class has no channel store, so it shows the last word
    reg [13:0] rd_mux;
    always @*
    begin
        case (read_class_q)
            `CLASS_DATA:   rd_mux = rd_data;
            `CLASS_OFFSET: rd_mux = rd_offset;
            `CLASS_GAIN:   rd_mux = rd_gain;
            default:       rd_mux = special_data_q;
        endcase
    end

    // ==========================================================
    // Write-port capture and control registers
    // ==========================================================
    // A write lands on the single access edge, like the strobe's rising edge
    // Channel pulse is rebuilt every cycle, so it lasts exactly one
    // A control write with bit 0 low lifts the clamp;
    // writing it high clamps the outputs again
    always @(posedge pclk or negedge presetn)
    begin
        // Reset leaves the outputs clamped until software lifts it
        if (!presetn)
        begin
            output_clear_state <= `RST_CONTROL;          // see RL6
            class_select_q     <= 2'h0;
            chan_write_q       <= 40'h00_0000_0000;
            special_write_q    <= 1'b0;
            special_data_q     <= 14'h0000;
            read_sel_q         <= 6'h00;
            read_class_q       <= 2'h0;
        end
        else
        begin
            special_write_q <= 1'b0;
            chan_write_q    <= wr_chans;
            if (hit_wr)
            begin
                class_select_q <= wr_class;              // see RL8
                if (wr_class == `CLASS_SPECIAL)          // see RL7
                begin
                    special_write_q <= 1'b1;
                    special_data_q  <= wr_word;
                end
            end
            if (wr_acc && paddr == `OFF_CONTROL)
                output_clear_state <= pwdata[0];         // Software release
            if (wr_acc && paddr == `OFF_READ_SEL)
            begin
                read_sel_q   <= pwdata[5:0];
                read_class_q <= pwdata[9:8];
            end
        end
    end

    // ==========================================================
    // APB answer: writes one wait, reads two
    // ==========================================================
    // Reads wait a cycle so memory readback can settle into its register
    // A bad address raises pslverr with pready; nothing is stored
    // Limitation: a host that drops psel mid-read leaves the pending
    // flag set, so its next read answers one cycle early
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            prdata       <= 32'h0000_0000;
            rd_pending_q <= 1'b0;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (access && !pready)
            begin
                if (pwrite)
                begin
                    pready  <= 1'b1;
                    pslverr <= !(paddr == `OFF_WRITE || paddr == `OFF_CONTROL ||
                                 paddr == `OFF_READ_SEL);
                end
                else if (!rd_pending_q)
                    rd_pending_q <= 1'b1;
                else
                begin
                    rd_pending_q <= 1'b0;
                    pready       <= 1'b1;
                    case (paddr)
                        `OFF_CONTROL:   prdata <= {31'h0, output_clear_state};
                        `OFF_STATUS:    prdata <= {28'h0, special_write_q, 1'b0,
                                                   class_select_q};
                        `OFF_READ_SEL:  prdata <= {22'h0, read_class_q, 2'h0,
                                                   read_sel_q};
                        `OFF_READ_DATA: prdata <= {18'h0, rd_mux};
                        default:
                        begin
                            prdata  <= 32'h0000_0000;
                            pslverr <= (paddr != `OFF_WRITE);
                        end
                    endcase
                end
            end
        end
    end

endmodule

// ==== verification/dac_decoder_properties.sv ====
// ==========================================
// Write-port decode checks
// ==========================================
module dac_decoder_properties
(
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        output_clear_state,
    input logic [1:0]  class_select_q,
    input logic [39:0] chan_write_q,
    input logic        special_write_q,
    input logic [13:0] special_data_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_take;   // Write to the write-port word this edge
    logic release_take; // Control write releasing the clamp
    logic fresh;     // Write access accepted this edge
    assign fresh = psel && penable && !pready && pwrite;
    assign wr_take = fresh && (paddr == 12'h000);
    assign release_take = fresh && (paddr == 12'h004) && !pwdata[0];
    // Channels a mask and index reach; with a group mask, index above 9 reaches none
    function automatic logic [39:0] reach(input logic [3:0] m, input logic [3:0] i);
        reach = '0;
        for (int g = 0; g < 4; g++)
            if (m[g] || m == 4'h0)
                reach[g*10 +: 10] = (m == 4'h0) ? 10'h3ff : 10'h001 << i;
    endfunction
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_write_ready: assert property (fresh |=> pready ##1 !pready)
        else $error("write not answered in one cycle");
    a_all_chan: assert property (
        wr_take && pwdata[23:20] == 4'h0 && pwdata[25:24] != 2'h0 |=> &chan_write_q)
        else $error("broadcast missed a channel");
    a_group_decode: assert property (
        wr_take && pwdata[23:20] != 4'h0 && pwdata[25:24] != 2'h0
        |=> chan_write_q == reach($past(pwdata[23:20]), $past(pwdata[19:16])))
        else $error("group decode wrong");
    a_bad_index: assert property (
        wr_take && pwdata[23:20] != 4'h0 && pwdata[19:16] > 4'h9 |=> chan_write_q == '0)
        else $error("undefined index wrote");
    a_idle_quiet: assert property (!wr_take |=> chan_write_q == '0)
        else $error("channel pulse without write");
    a_class_track: assert property (wr_take |=> class_select_q == $past(pwdata[25:24]))
        else $error("class not tracked");
    a_special_word: assert property (
        wr_take && pwdata[25:24] == 2'h0
        |=> special_write_q && special_data_q == $past(pwdata[13:0]))
        else $error("special word lost");
    a_clear_release: assert property ($fell(output_clear_state) |-> $past(release_take))
        else $error("clamp dropped without control write");
    cover property (wr_take && pwdata[23:20] == 4'h0);
    cover property (wr_take && pwdata[19:16] > 4'h9);
    cover property ($fell(output_clear_state));
endmodule

bind dac_channel_address_decoder dac_decoder_properties chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .output_clear_state(output_clear_state), .class_select_q(class_select_q),
    .chan_write_q(chan_write_q), .special_write_q(special_write_q),
    .special_data_q(special_data_q));

// ==== verification/apb_host.sv ====
// ==========================================
// Host controller driving the write port
// ==========================================
module apb_host
(
    input  logic        pclk,
    input  logic [31:0] prdata,
    input  logic        pready,
    input  logic        pslverr,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // One transfer; request held until ready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines stop showing the old value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ==== verification/tb_top.sv ====
`include "dac_addr_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, output_clear_state, special_write_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  class_select_q;
    logic [39:0] chan_write_q, cap;
    logic [13:0] special_data_q;
    logic [3:0]  ix;
    logic        er, special_seen;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc = 0;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
    always #20 pclk = ~pclk;
    dac_channel_address_decoder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .output_clear_state(output_clear_state),
        .class_select_q(class_select_q), .chan_write_q(chan_write_q),
        .special_write_q(special_write_q), .special_data_q(special_data_q));
    apb_host host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    task test_done;
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Pulses stand beside the answer; keep them, and cut a hang short
    always @(posedge pclk)
    begin
        cyc++;
        if (pready === 1'b1)
        begin
            cap <= chan_write_q;
            special_seen <= special_write_q;
        end
        if (cyc == 5000)
        begin
            n_mismatch++;
            test_done;
        end
    end
    function automatic logic [39:0] reach(input logic [3:0] m, input logic [3:0] i);
        reach = '0;
        for (int g = 0; g < 4; g++)
            if (m[g] || m == 4'h0)
                reach[g*10 +: 10] = (m == 4'h0) ? 10'h3ff : 10'h001 << i;
    endfunction
    task wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q, er);
        @(negedge pclk);
    endtask
    task rd(input logic [11:0] a);
        host_u.xfer(1'b0, a, 32'h0000_0000, q, er);
        @(negedge pclk);
    endtask
    // Read back one channel word of one class
    task peek(input logic [1:0] c, input logic [5:0] ch);
        wr(12'h00c, {22'h0, c, 2'h0, ch});
        rd(12'h010);
    endtask
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("clamp", 1'b1, output_clear_state)
        for (int c = 1; c < 4; c++)
        begin
            peek(c[1:0], 6'h05);
            `CHK("reset", c == 3 ? `RST_DATA : c == 2 ? `RST_OFFSET : `RST_GAIN, q[13:0])
        end
        // Every mask; broadcast gets an index that must be ignored
        for (int m = 0; m < 16; m++)
        begin
            ix = (m == 0) ? 4'hc : 4'(m % 10);
            wr(12'h000, {6'h0, `CLASS_DATA, m[3:0], ix, 2'h0, 14'h0100});
            `CHK("chans", reach(m[3:0], ix), cap)
        end
        wr(12'h000, {6'h0, `CLASS_DATA, 4'h5, 4'hb, 16'h0155});
        `CHK("bad idx", 40'h00_0000_0000, cap)
        for (int c = 1; c < 4; c++)
        begin
            wr(12'h000, {6'h0, c[1:0], 4'h8, 4'h9, 2'h0, 14'h1230 + 14'(c)});
            `CHK("class", c[1:0], class_select_q)
            peek(c[1:0], 6'd39);
            `CHK("readback", 14'h1230 + 14'(c), q[13:0])
        end
        wr(12'h000, {6'h0, `CLASS_SPECIAL, 4'h3, 4'h2, 2'h0, 14'h0abc});
        `CHK("special pulse", 1'b1, special_seen)
        `CHK("special word", 14'h0abc, special_data_q)
        wr(12'h004, 32'h0000_0000);
        `CHK("release", 1'b0, output_clear_state)
        `CHK("ctrl err", 1'b0, er)
        rd(12'h020);
        `CHK("unmapped", 1'b1, er)
        wr(12'h008, 32'h0000_0000);
        `CHK("ro write", 1'b1, er)
        rd(12'h004);
        `CHK("ctrl read", 32'h0000_0000, q)
        peek(`CLASS_SPECIAL, 6'h00);
        `CHK("special read", 14'h0abc, q[13:0])
        // Reset again in mid-run: the clamp and the data store must come back
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        `CHK("clamp again", 1'b1, output_clear_state)
        peek(`CLASS_DATA, 6'd39);
        `CHK("data cleared", `RST_DATA, q[13:0])
        test_done;
    end
endmodule
